//--- logic/lled_pkg.sv
// package for the link-layer error and debug status bank
// assumes a 32-bit avalon-mm register bus with byte addresses
package lled_pkg;
    localparam int AW = 32;
    // register byte addresses
    localparam logic [31:0] ADR_DIAG_CTRL = 32'h40000050;
    localparam logic [31:0] ADR_DIAG_VIEW = 32'h40000054;
    localparam logic [31:0] ADR_ZONE_UP = 32'h40000058;
    localparam logic [31:0] ADR_ZONE_LO = 32'h4000005c;
    localparam logic [31:0] ADR_ERR = 32'h40000060;
    localparam logic [31:0] ADR_PROF = 32'h40000064;
    localparam logic [31:0] ADR_RADIO0 = 32'h40000070;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [31:0] RST_RADIO0 = 32'h00000002;
    // writable bits of the radio control word
    localparam logic [31:0] RADIO0_MASK = 32'h00fc0062;
    // diag control: per port enable at 8n+7, select at 8n+5..8n
    localparam int DIAG_EN_POS = 7;
    localparam int DIAG_SEL_W = 6;
    localparam int DIAG_PORTS = 4;
    localparam int DIAG_SRCS = 64;
    localparam int PROF_SRCS = 4;
    // zone bound halves
    localparam int REG_HALF_LSB = 16;
    // error flag positions
    localparam int E_TXENC = 0;
    localparam int E_RXDEC = 1;
    localparam int E_PKTMEM = 2;
    localparam int E_RADMEM = 3;
    localparam int E_SCHMEM = 4;
    localparam int E_SCHENT = 5;
    localparam int E_SCHPF = 6;
    localparam int E_EVTPF = 7;
    localparam int E_ACL = 8;
    localparam int E_IFS = 9;
    localparam int E_ADV = 10;
    localparam int E_CHMAP = 11;
    localparam int E_FMT = 12;
    localparam int E_TXDESC = 13;
    localparam int E_RXDESC = 14;
    localparam int E_TXBUF = 15;
    localparam int E_RXBUF = 16;
    localparam int E_IRQ = 17;
    localparam int ERR_W = 18;
    localparam int CHMAP_W = 37;

    // pointer and channel-map checks, one strobe per check
    typedef struct packed {
        logic rx_buf_chk;
        logic [15:0] rx_buf_ptr;
        logic rx_desc_chk;
        logic [15:0] rx_desc_ptr;
        logic tx_buf_chk;
        logic adv_scan_init;
        logic [7:0] pkt_len;
        logic [15:0] tx_buf_ptr;
        logic tx_desc_chk;
        logic [15:0] tx_desc_ptr;
        logic hop_start;
        logic [36:0] chan_map;
        logic [5:0] good_count;
    } lled_chk_s;

    // one-cycle failure pulses from the sub-blocks
    typedef struct packed {
        logic unacked_irq;
        logic fmt_bad;
        logic adv_short;
        logic ifs_short;
        logic acl_timeout;
        logic evt_prefetch;
        logic sch_prefetch;
        logic sch_entry;
        logic sch_mem;
        logic radio_mem;
        logic pkt_mem;
        logic rx_dec_late;
        logic tx_enc_late;
    } lled_evt_s;
endpackage : lled_pkg

//--- logic/lled_regs.sv
// link-layer error, debug address window and diagnostic status bank
// assumes sub-block inputs on i_sys_clk; avalon-mm slave, byte address
// Overview of operation
// (RQ1) status word mirrors four debug buses, bus three top byte, read only
// (RQ2) writable upper bounds: register zone high half, exchange zone low half
// (RQ3) writable lower bounds: register zone high half, exchange zone low half
// (RQ4) zone hit flag high while address within both bounds inclusive
// (RQ5) bit 17 set on two concurrent event irqs left unacknowledged
// (RQ6) bit 16 set when programmed receive buffer pointer is zero
// (RQ7) bit 15 set on zero transmit buffer pointer in adv/scan or nonempty packet
// (RQ8) bit 14 set when receive descriptor pointer is zero
// (RQ9) bit 13 set when transmit descriptor pointer zero during adv/scan/init
// (RQ10) bit 12 set on invalid control-structure format
// (RQ11) bit 11 set when channel map ones differ from good count at hop start
// (RQ12) bit 10 set when advertising packets come too close together
// (RQ13) bit 9 set when inter-frame space is too short
// (RQ14) bit 8 set when accept-list parsing times out
// (RQ15) bits 7 and 6 set on anticipated prefetch overrun
// (RQ16) bit 5 set on invalid timing across two exchange-table entries
// (RQ17) bit 4 set when scheduler memory access is served late
// (RQ18) bit 3 set when radio memory access is served late
// (RQ19) bit 2 set when packet memory access is served late
// (RQ20) bit 1 set when block decryption finishes late
// (RQ21) bit 0 set when block encryption is not ready in time
// (RQ22) profiling word is read-write and copied onto the diagnostic port
// (RQ23) error flags read only, reset to zero, sticky until reset
// (RQ24) disabled diagnostic port drives zero, enabled port follows its select
`timescale 1ns/100ps
`default_nettype none
module lled_regs #(
    parameter int EXT_SRCS = 60
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [31:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [15:0] i_reg_acc_addr,
    input wire logic [15:0] i_em_acc_addr,
    output logic o_register_zone_hit,
    output logic o_exchange_zone_hit,
    input wire lled_pkg::lled_chk_s i_chk,
    input wire lled_pkg::lled_evt_s i_evt,
    input wire logic [EXT_SRCS*8-1:0] i_diag_src,
    output logic [31:0] o_diag_ports,
    output logic [31:0] o_radio_ctrl
);
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] diag_ctrl_q;
    logic [31:0] zone_up_q;
    logic [31:0] zone_lo_q;
    logic [31:0] prof_q;
    logic [31:0] radio_q;
    logic [lled_pkg::ERR_W-1:0] err_q;
    logic [lled_pkg::ERR_W-1:0] err_set;
    logic [31:0] diag_q;
    logic reg_hit_q;
    logic em_hit_q;
    logic req;
    logic wr_go;
    logic [7:0] src [lled_pkg::DIAG_SRCS];

    // merge write data into a word under the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // number of used channels in the map
    function automatic logic [5:0] ones(input logic [36:0] m);
        logic [5:0] n;
        n = 6'h00;
        for (int b = 0; b < lled_pkg::CHMAP_W; b++) begin
            n = n + {5'h00, m[b]};
        end
        return n;
    endfunction : ones

    assign req = i_avs_read | i_avs_write;
    // a write lands on the edge where waitrequest is seen low
    assign wr_go = i_avs_write & ~wait_q;

    // one wait cycle per access: low for exactly one cycle, then high again
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_q <= 1'b1;
        end else if (req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // read data captured at the request edge; unmapped reads return zero
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= lled_pkg::RST_ZERO;
        end else if (i_avs_read && wait_q) begin
            unique case (i_avs_address)
                lled_pkg::ADR_DIAG_CTRL: rdata_q <= diag_ctrl_q;
                lled_pkg::ADR_DIAG_VIEW: rdata_q <= diag_q; // RQ1
                lled_pkg::ADR_ZONE_UP: rdata_q <= zone_up_q;
                lled_pkg::ADR_ZONE_LO: rdata_q <= zone_lo_q;
                lled_pkg::ADR_ERR: rdata_q <= {14'h0, err_q}; // RQ23
                lled_pkg::ADR_PROF: rdata_q <= prof_q;
                lled_pkg::ADR_RADIO0: rdata_q <= radio_q;
                default: rdata_q <= lled_pkg::RST_ZERO;
            endcase
        end
    end

    // diagnostic port control: enable and select per port
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            diag_ctrl_q <= lled_pkg::RST_ZERO;
        end else if (wr_go && i_avs_address == lled_pkg::ADR_DIAG_CTRL) begin
            diag_ctrl_q <= merge(diag_ctrl_q, i_avs_writedata, i_avs_byteenable)
                & 32'hbfbfbfbf; // bit 6 of each byte is unused
        end
    end

    // zone bounds, both fully writable
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            zone_up_q <= lled_pkg::RST_ZERO;
            zone_lo_q <= lled_pkg::RST_ZERO;
        end else if (wr_go) begin
            if (i_avs_address == lled_pkg::ADR_ZONE_UP) begin
                zone_up_q <= merge(zone_up_q, i_avs_writedata, i_avs_byteenable); // RQ2
            end
            if (i_avs_address == lled_pkg::ADR_ZONE_LO) begin
                zone_lo_q <= merge(zone_lo_q, i_avs_writedata, i_avs_byteenable); // RQ3
            end
        end
    end

    // profiling word, also a source for the diagnostic ports
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prof_q <= lled_pkg::RST_ZERO;
        end else if (wr_go && i_avs_address == lled_pkg::ADR_PROF) begin
            prof_q <= merge(prof_q, i_avs_writedata, i_avs_byteenable); // RQ22
        end
    end

    // radio control word; bit 0 is write-only with no known effect, so it reads zero
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            radio_q <= lled_pkg::RST_RADIO0;
        end else if (wr_go && i_avs_address == lled_pkg::ADR_RADIO0) begin
            radio_q <= merge(radio_q, i_avs_writedata, i_avs_byteenable)
                & lled_pkg::RADIO0_MASK;
        end
    end

    // zone hit, inclusive bounds; one cycle behind the access address
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            reg_hit_q <= 1'b0;
            em_hit_q <= 1'b0;
        end else begin
            reg_hit_q <= (i_reg_acc_addr >= zone_lo_q[31:16])
                && (i_reg_acc_addr <= zone_up_q[31:16]); // RQ4
            em_hit_q <= (i_em_acc_addr >= zone_lo_q[15:0])
                && (i_em_acc_addr <= zone_up_q[15:0]); // RQ4
        end
    end

    // error detection: pointer and map checks done here, the rest pulsed in
    always_comb begin
        err_set = '0;
        err_set[lled_pkg::E_IRQ] = i_evt.unacked_irq; // RQ5
        err_set[lled_pkg::E_RXBUF] = i_chk.rx_buf_chk
            && i_chk.rx_buf_ptr == 16'h0000; // RQ6
        err_set[lled_pkg::E_TXBUF] = i_chk.tx_buf_chk
            && i_chk.tx_buf_ptr == 16'h0000
            && (i_chk.adv_scan_init || i_chk.pkt_len != 8'h00); // RQ7
        err_set[lled_pkg::E_RXDESC] = i_chk.rx_desc_chk
            && i_chk.rx_desc_ptr == 16'h0000; // RQ8
        err_set[lled_pkg::E_TXDESC] = i_chk.tx_desc_chk && i_chk.adv_scan_init
            && i_chk.tx_desc_ptr == 16'h0000; // RQ9
        err_set[lled_pkg::E_FMT] = i_evt.fmt_bad; // RQ10
        err_set[lled_pkg::E_CHMAP] = i_chk.hop_start
            && ones(i_chk.chan_map) != i_chk.good_count; // RQ11
        err_set[lled_pkg::E_ADV] = i_evt.adv_short; // RQ12
        err_set[lled_pkg::E_IFS] = i_evt.ifs_short; // RQ13
        err_set[lled_pkg::E_ACL] = i_evt.acl_timeout; // RQ14
        err_set[lled_pkg::E_EVTPF] = i_evt.evt_prefetch; // RQ15
        err_set[lled_pkg::E_SCHPF] = i_evt.sch_prefetch; // RQ15
        err_set[lled_pkg::E_SCHENT] = i_evt.sch_entry; // RQ16
        err_set[lled_pkg::E_SCHMEM] = i_evt.sch_mem; // RQ17
        err_set[lled_pkg::E_RADMEM] = i_evt.radio_mem; // RQ18
        err_set[lled_pkg::E_PKTMEM] = i_evt.pkt_mem; // RQ19
        err_set[lled_pkg::E_RXDEC] = i_evt.rx_dec_late; // RQ20
        err_set[lled_pkg::E_TXENC] = i_evt.tx_enc_late; // RQ21
    end

    // sticky flags; no clear exists so only reset drops them
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            err_q <= '0;
        end else begin
            err_q <= err_q | err_set; // RQ23
        end
    end

    // diagnostic sources: profiling bytes first, then external groups
    generate
        for (genvar s = 0; s < lled_pkg::DIAG_SRCS; s++) begin : g_src
            if (s < lled_pkg::PROF_SRCS) begin : g_prof
                assign src[s] = prof_q[s*8 +: 8]; // RQ22
            end else if (s - lled_pkg::PROF_SRCS < EXT_SRCS) begin : g_ext
                assign src[s] = i_diag_src[(s-lled_pkg::PROF_SRCS)*8 +: 8];
            end else begin : g_nil
                assign src[s] = 8'h00;
            end
        end
    endgenerate

    // each port: zero when disabled, else the selected byte
    generate
        for (genvar p = 0; p < lled_pkg::DIAG_PORTS; p++) begin : g_port
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    diag_q[p*8 +: 8] <= 8'h00;
                end else if (diag_ctrl_q[p*8 + lled_pkg::DIAG_EN_POS]) begin
                    diag_q[p*8 +: 8] <= src[diag_ctrl_q[p*8 +: lled_pkg::DIAG_SEL_W]]; // RQ24
                end else begin
                    diag_q[p*8 +: 8] <= 8'h00; // RQ24
                end
            end
        end
    endgenerate

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_register_zone_hit = reg_hit_q;
    assign o_exchange_zone_hit = em_hit_q;
    assign o_diag_ports = diag_q;
    assign o_radio_ctrl = radio_q;
endmodule : lled_regs
`default_nettype wire

//--- verification/lled_regs_assertions.sv
// checker on the ports of the error and debug status bank
// assumes whole-word writes to the shadowed words, so byte enables are not modelled
`timescale 1ns/100ps
`default_nettype none
module lled_regs_assertions #(
    parameter int EXT_SRCS = 60
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [31:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [15:0] i_reg_acc_addr,
    input wire logic [15:0] i_em_acc_addr,
    input wire logic o_register_zone_hit,
    input wire logic o_exchange_zone_hit,
    input wire lled_pkg::lled_chk_s i_chk,
    input wire lled_pkg::lled_evt_s i_evt,
    input wire logic [EXT_SRCS*8-1:0] i_diag_src,
    input wire logic [31:0] o_diag_ports,
    input wire logic [31:0] o_radio_ctrl
);
    logic [31:0] up_q, lo_q, ctl_q, prof_q;
    logic [17:0] exp_q;
    logic rdy_q, in_em, in_reg, wr_done, rd_take;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // a write lands at the edge where the wait ends
    assign wr_done = i_avs_write && !o_avs_waitrequest;
    assign rd_take = i_avs_read && o_avs_waitrequest;
    assign in_em = i_em_acc_addr >= lo_q[15:0] && i_em_acc_addr <= up_q[15:0];
    assign in_reg = i_reg_acc_addr >= lo_q[31:16] && i_reg_acc_addr <= up_q[31:16];
    // shadow words; rdy_q skips the first edge, whose flops still hold reset
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {up_q, lo_q, ctl_q, prof_q} <= '0;
            exp_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= 1'b1;
            exp_q <= exp_q | {i_evt[12], 4'h0, i_evt[11], 1'b0, i_evt[10:0]};
            if (wr_done && i_avs_address == lled_pkg::ADR_ZONE_UP) up_q <= i_avs_writedata;
            if (wr_done && i_avs_address == lled_pkg::ADR_ZONE_LO) lo_q <= i_avs_writedata;
            if (wr_done && i_avs_address == lled_pkg::ADR_DIAG_CTRL) ctl_q <= i_avs_writedata;
            if (wr_done && i_avs_address == lled_pkg::ADR_PROF) prof_q <= i_avs_writedata;
        end
    end
    wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus answer late");
    wait_drop_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("wait low for two cycles");
    view_read_a: assert property (
        rd_take && i_avs_address == lled_pkg::ADR_DIAG_VIEW
        |=> o_avs_readdata == $past(o_diag_ports)) else $error("status word differs");
    em_zone_a: assert property (
        rdy_q |-> o_exchange_zone_hit == $past(in_em)) else $error("exchange hit wrong");
    reg_zone_a: assert property (
        rdy_q |-> o_register_zone_hit == $past(in_reg)) else $error("register hit wrong");
    err_sticky_a: assert property (
        rd_take && i_avs_address == lled_pkg::ADR_ERR |=> o_avs_readdata[31:18] == 14'h0
        && (o_avs_readdata[17:0] & $past(exp_q)) == $past(exp_q)) else $error("flag lost");
    port_off_a: assert property (
        !ctl_q[7] |=> o_diag_ports[7:0] == 8'h00) else $error("disabled port not zero");
    prof_copy_a: assert property (
        ctl_q[7:0] == 8'h80 ##1 $stable(prof_q) |-> o_diag_ports[7:0] == prof_q[7:0])
        else $error("port does not copy profiling byte");
endmodule : lled_regs_assertions
bind lled_regs lled_regs_assertions #(.EXT_SRCS(EXT_SRCS)) lled_regs_assertions_i (
    .i_sys_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_reg_acc_addr,
    .i_em_acc_addr, .o_register_zone_hit, .o_exchange_zone_hit, .i_chk, .i_evt,
    .i_diag_src, .o_diag_ports, .o_radio_ctrl
);
`default_nettype wire

//--- verification/lled_subblk_model.sv
// model of the link-layer sub-blocks: check strobes, failure pulses, debug bytes
// assumes one caller at a time; strobes and pulses last one clock cycle
`timescale 1ns/100ps
`default_nettype none
module lled_subblk_model #(
    parameter int EXT_SRCS = 60
) (
    input wire logic i_sys_clk,
    output var lled_pkg::lled_chk_s o_chk,
    output var lled_pkg::lled_evt_s o_evt,
    output logic [EXT_SRCS*8-1:0] o_diag_src
);
    // every debug byte differs, so a wrong select cannot pass unseen
    initial begin
        o_chk = '0;
        o_evt = '0;
        for (int n = 0; n < EXT_SRCS; n++) o_diag_src[n*8 +: 8] = 8'h30 + 8'(n);
    end
    // drive one cycle after an edge, then return to idle
    task automatic pulse(input lled_pkg::lled_chk_s c, input lled_pkg::lled_evt_s e);
        @(posedge i_sys_clk);
        o_chk <= c;
        o_evt <= e;
        @(posedge i_sys_clk);
        o_chk <= '0;
        o_evt <= '0;
    endtask : pulse
endmodule : lled_subblk_model
`default_nettype wire

//--- verification/lled_regs_tb.sv
// self-checking bench for the error and debug status bank
// assumes a 250 MHz clock; bus writes carry all four bytes unless a scenario narrows them
`timescale 1ns/100ps
`default_nettype none
module lled_regs_tb;
    localparam int NS = 60;
    logic i_sys_clk, i_resetn, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic o_register_zone_hit, o_exchange_zone_hit;
    logic [31:0] i_avs_address, i_avs_writedata, o_avs_readdata, o_diag_ports, o_radio_ctrl, q;
    logic [15:0] i_reg_acc_addr, i_em_acc_addr;
    logic [3:0] i_avs_byteenable;
    logic [17:0] e;
    lled_pkg::lled_chk_s i_chk, c;
    lled_pkg::lled_evt_s i_evt;
    logic [NS*8-1:0] i_diag_src;
    int n_mismatch, comparisons, cyc;
    lled_regs #(.EXT_SRCS(NS)) lled_regs_i (
        .i_sys_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
        .i_reg_acc_addr, .i_em_acc_addr, .o_register_zone_hit, .o_exchange_zone_hit,
        .i_chk, .i_evt, .i_diag_src, .o_diag_ports, .o_radio_ctrl
    );
    lled_subblk_model #(.EXT_SRCS(NS)) lled_subblk_model_i (
        .i_sys_clk, .o_chk(i_chk), .o_evt(i_evt), .o_diag_src(i_diag_src)
    );
    always #2 i_sys_clk = ~i_sys_clk;
    // hang guard: the run needs well under a thousand cycles
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        @(posedge i_sys_clk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_sys_clk);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        check(q, exp);
    endtask : rdchk
    task automatic do_reset();
        i_resetn <= 1'b0;
        e = '0;
        repeat (16) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
    endtask : do_reset
    // one failure report, then the flag word with all flags raised so far
    task automatic chkerr(input lled_pkg::lled_chk_s s, input lled_pkg::lled_evt_s v, input int b);
        lled_subblk_model_i.pulse(s, v);
        if (b >= 0) e[b] = 1'b1;
        rdchk(lled_pkg::ADR_ERR, {14'h0, e});
    endtask : chkerr
    task automatic t_reset_vals();
        rdchk(lled_pkg::ADR_DIAG_VIEW, '0);
        rdchk(lled_pkg::ADR_ZONE_UP, '0);
        rdchk(lled_pkg::ADR_ZONE_LO, '0);
        rdchk(lled_pkg::ADR_ERR, '0);
        rdchk(lled_pkg::ADR_PROF, '0);
        rdchk(lled_pkg::ADR_RADIO0, 32'h00000002);
        rdchk(32'h40000068, '0);
    endtask : t_reset_vals
    // read-only places ignore writes, radio word keeps only writable bits
    task automatic t_access();
        bus(1'b1, lled_pkg::ADR_PROF, 32'ha5c31e77);
        bus(1'b1, lled_pkg::ADR_ERR, 32'hffffffff);
        bus(1'b1, lled_pkg::ADR_DIAG_VIEW, 32'hffffffff);
        bus(1'b1, 32'h40000068, 32'hffffffff);
        bus(1'b1, lled_pkg::ADR_RADIO0, 32'hffffffff);
        rdchk(lled_pkg::ADR_PROF, 32'ha5c31e77);
        rdchk(lled_pkg::ADR_ERR, '0);
        rdchk(lled_pkg::ADR_DIAG_VIEW, '0);
        rdchk(lled_pkg::ADR_RADIO0, 32'h00fc0062);
        check(o_radio_ctrl, 32'h00fc0062);
        // a narrowed write must touch only its own byte
        i_avs_byteenable <= 4'h4;
        bus(1'b1, lled_pkg::ADR_RADIO0, 32'h00000000);
        i_avs_byteenable <= 4'hf;
        rdchk(lled_pkg::ADR_RADIO0, 32'h00000062);
    endtask : t_access
    // both bounds inclusive, one step outside each end misses
    task automatic t_zone();
        logic [15:0] ea[4] = '{16'h010f, 16'h0110, 16'h0120, 16'h0121};
        logic [15:0] ra[4] = '{16'h00ff, 16'h0100, 16'h0200, 16'h0201};
        bus(1'b1, lled_pkg::ADR_ZONE_UP, 32'h02000120);
        bus(1'b1, lled_pkg::ADR_ZONE_LO, 32'h01000110);
        rdchk(lled_pkg::ADR_ZONE_UP, 32'h02000120);
        rdchk(lled_pkg::ADR_ZONE_LO, 32'h01000110);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_sys_clk);
            i_em_acc_addr <= ea[k];
            i_reg_acc_addr <= ra[k];
            repeat (2) @(posedge i_sys_clk);
            q = {30'h0, o_register_zone_hit, o_exchange_zone_hit};
            check(q, (k % 3) ? 32'h3 : 32'h0);
        end
    endtask : t_zone
    // port0 profiling byte0, port1 byte1, port2 off, port3 source byte1
    task automatic t_diag();
        bus(1'b1, lled_pkg::ADR_DIAG_CTRL, 32'h85428180);
        rdchk(lled_pkg::ADR_DIAG_CTRL, 32'h85028180);
        check(o_diag_ports, 32'h31001e77);
        rdchk(lled_pkg::ADR_DIAG_VIEW, 32'h31001e77);
    endtask : t_diag
    task automatic t_err();
        lled_pkg::lled_evt_s v;
        int t;
        c = '0;
        c.tx_buf_chk = 1'b1;
        chkerr(c, '0, -1);
        c = '0;
        c.hop_start = 1'b1;
        c.chan_map = 37'h1f;
        c.good_count = 6'd5;
        chkerr(c, '0, -1);
        for (int k = 0; k < 13; k++) begin
            v = lled_pkg::lled_evt_s'(13'h1 << k);
            t = k < 11 ? k : (k == 11 ? 12 : 17);
            chkerr('0, v, t);
        end
        c.good_count = 6'd6;
        chkerr(c, '0, 11);
        c = '0;
        c.rx_buf_chk = 1'b1;
        chkerr(c, '0, 16);
        c = '0;
        c.tx_buf_chk = 1'b1;
        c.pkt_len = 8'h04;
        chkerr(c, '0, 15);
        c = '0;
        c.rx_desc_chk = 1'b1;
        chkerr(c, '0, 14);
        c = '0;
        c.tx_desc_chk = 1'b1;
        c.adv_scan_init = 1'b1;
        chkerr(c, '0, 13);
    endtask : t_err
    initial begin
        i_sys_clk = 1'b0;
        i_resetn = 1'b0;
        {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
        {i_reg_acc_addr, i_em_acc_addr} = '0;
        i_avs_byteenable = 4'hf;
        do_reset();
        t_reset_vals();
        t_access();
        t_zone();
        t_diag();
        t_err();
        do_reset();
        t_reset_vals();
        summarize();
    end
endmodule : lled_regs_tb
`default_nettype wire
